// ==== edge_sync.sv ====
// Two-stage synchroniser with rise and fall detection
module edge_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_in,
  output logic      o_rise,
  output logic      o_fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;
  sync_t r, next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = i_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= 3'h7;
    end else begin
      r <= next_r;
    end
  end

  // Edges come from stages two and three only, so one pulse gives one event
  assign o_rise = r.s2 & ~r.s3;
  assign o_fall = ~r.s2 & r.s3;
endmodule

// ==== interval_timer.sv ====
// Interval timer for the timer trigger source
module interval_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clear,
  input  wire logic        i_consume,
  input  wire logic [31:0] i_interval,
  output logic             o_ready
);
  typedef struct packed {
    logic        first;
    logic        expired;
    logic [31:0] count;
  } tmr_t;
  tmr_t r, next_r;

  always_comb begin
    next_r = r;
    if (i_clear) begin
      next_r.first   = 1'b1;
      next_r.expired = 1'b0;
      next_r.count   = 32'h0;
    end else begin
      if (!r.expired && !r.first) begin
        if (r.count + 32'h1 >= i_interval) begin
          next_r.expired = 1'b1;
        end else begin
          next_r.count = r.count + 32'h1;
        end
      end
      if (i_consume) begin
        next_r.first   = 1'b0;
        next_r.expired = 1'b0;
        next_r.count   = 32'h0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '{first: 1'b1, expired: 1'b0, count: 32'h0};
    end else begin
      r <= next_r;
    end
  end

  assign o_ready = r.first | r.expired;
endmodule

// ==== trig_partner.sv ====
// Far-side model: trigger link instruments and start-of-test source
module trig_partner (
  input  wire logic       i_clk,
  input  wire logic [5:0] i_oe,
  output logic [5:0]      o_link,
  output logic            o_sot
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pull = 6'h00;
  // Lines are pulled up, so a released line reads high
  assign o_link = ~(pull | i_oe);
  initial o_sot = 1'b1;
  // Held low four cycles so the synchroniser cannot miss it
  task automatic link_pulse(input int n);
    @(negedge i_clk) pull[n-1] = 1'b1;
    repeat (4) @(negedge i_clk);
    pull[n-1] = 1'b0;
  endtask
  task automatic sot_pulse(input logic lvl);
    @(negedge i_clk) o_sot = ~lvl;
    repeat (5) @(negedge i_clk);
    o_sot = lvl;
    repeat (5) @(negedge i_clk);
    o_sot = ~lvl;
  endtask
endmodule

// ==== trig_seq_params.svh ====
// Constants for the trigger layer sequencer
`ifndef TRIG_SEQ_PARAMS_SVH
`define TRIG_SEQ_PARAMS_SVH
`define CLK_HZ             40000000
`define SAMPLE_HZ          10000000
`define SAMPLE_DIV         (`CLK_HZ / `SAMPLE_HZ)
`define DELAY_MIN_US       20
`define DELAY_MAX_MS       500
`define DELAY_MAX_CYC      (`DELAY_MAX_MS * (`CLK_HZ / 1000))
`define WIDTH_MIN_NS       500
`define WIDTH_MIN_CYC      ((`WIDTH_MIN_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define WIDTH_MAX_MS       5
`define WIDTH_MAX_CYC      (`WIDTH_MAX_MS * (`CLK_HZ / 1000))
`define COUNT_MAX          5000
`define TIMER_DEF_MS       100
`define TIMER_DEF_CYC      (`TIMER_DEF_MS * (`CLK_HZ / 1000))
`define IN_LINE_DEF        3'h1
`define OUT_LINE_DEF       3'h2
`define OUT_PULSE_CYC      4
`endif

// ==== trig_seq_pkg.sv ====
// Types for the trigger layer sequencer
package trig_seq_pkg;
  typedef enum logic [2:0] {
    SRC_IMMEDIATE = 3'h0,
    SRC_BUS       = 3'h1,
    SRC_TIMER     = 3'h2,
    SRC_KEY       = 3'h3,
    SRC_LINK      = 3'h4,
    SRC_FALL      = 3'h5,
    SRC_RISE      = 3'h6,
    SRC_EITHER    = 3'h7
  } src_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WAIT  = 3'h1,
    ST_DELAY = 3'h2,
    ST_PULSE = 3'h3,
    ST_NEXT  = 3'h4,
    ST_EXIT  = 3'h5
  } seq_state_t;

  typedef struct packed {
    src_t        source;
    logic [2:0]  in_line;
    logic [2:0]  out_line;
    logic        out_enable;
    logic [12:0] trig_count;
    logic [12:0] sweep_points;
    logic [7:0]  filter_count;
    logic        sweep_enable;
    logic        filter_enable;
    logic [31:0] timer_cycles;
    logic [24:0] delay_cycles;
    logic [17:0] width_cycles;
    logic [24:0] duty_min_cycles;
  } cfg_t;

  typedef struct packed {
    logic initiate;
    logic abort;
    logic bus_trigger;
    logic default_restore;
    logic front_halt;
    logic front_resume;
    logic key_press;
    logic remote;
  } cmd_t;
endpackage

// ==== trigger_layer_sequencer.sv ====
// Trigger layer sequencer: idle, event detect, delay-pulse loops, output trigger
`include "trig_seq_params.svh"

// Functional notes
// - Idle takes no readings until initiate
// - In layer, only urgent commands act
// - Immediate source passes detection at once
// - Bus source waits for bus trigger
// - Timer: first pass immediate, reset on idle
// - Key source honoured only under local control
// - Link source on one of six lines
// - Start-of-test low, high or either pulse
// - Abort or front halt forces idle
// - Delay is a minimum, stretched for duty
// - One pulse, 10 MHz samples, one reading
// - Fixed amplitude, or per sweep point
// - Filter repeats loop, averages readings
// - Sweep repeats process per point
// - Trigger count repeats the layer
// - Count and count times points capped
// - Output trigger on layer exit if enabled
// - Output trigger on selectable link line
// - Default restore sets source, count, timer, output
// - Pulse mode or sweep start clears auto-rearm
// - Front halt idles without output off
// - One initiate, one cycle, back to idle
// - Factory lines: out two, in one
module trigger_layer_sequencer #(
  parameter int          LINES          = 6,
  parameter logic [31:0] TIMER_DEFAULT  = `TIMER_DEF_CYC,
  parameter int          OUT_PULSE      = `OUT_PULSE_CYC
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire trig_seq_pkg::cfg_t   i_cfg,
  input  wire logic                 i_cfg_write,
  input  wire trig_seq_pkg::cmd_t   i_cmd,
  input  wire logic                 i_pulse_mode,
  input  wire logic                 i_front_sweep_start,
  input  wire logic                 i_rearm_set,
  input  wire logic [LINES-1:0]     i_link_in,
  input  wire logic                 i_start_of_test_input,
  output logic                      o_idle,
  output logic                      o_pulse,
  output logic                      o_sample,
  output logic                      o_reading,
  output logic                      o_filtered_reading,
  output logic [12:0]               o_sweep_point,
  output logic                      o_cmd_deferred,
  output logic                      o_auto_rearm,
  output logic                      o_layer_exit_output_event,
  output logic [LINES-1:0]          o_link_out,
  output logic [LINES-1:0]          o_link_oe,
  output logic                      o_cfg_rejected,
  output logic [2:0]                o_source
);
  typedef struct packed {
    trig_seq_pkg::seq_state_t state;
    trig_seq_pkg::cfg_t       cfg;
    logic [24:0]              phase_cnt;
    logic [1:0]               sample_div;
    logic [7:0]               filt_cnt;
    logic [12:0]              point_cnt;
    logic [12:0]              trig_cnt;
    logic                     auto_rearm;
    logic [3:0]               out_cnt;
    logic                     out_evt;
    logic                     idle;
    logic                     pulse;
    logic                     sample;
    logic                     reading;
    logic                     filtered;
    logic                     deferred;
    logic                     rejected;
    logic [LINES-1:0]         link_out;
    logic [LINES-1:0]         link_oe;
  } seq_t;
  seq_t r, next_r;

  logic [LINES-1:0] link_rise;
  logic [LINES-1:0] link_fall;
  logic             sot_rise;
  logic             sot_fall;
  logic             timer_ready;
  logic             timer_clear;
  logic             timer_consume;
  logic             detect;

  // Factory and bus-default configuration
  function automatic trig_seq_pkg::cfg_t default_cfg(input trig_seq_pkg::cfg_t base);
    trig_seq_pkg::cfg_t c;
    c              = base;
    c.source       = trig_seq_pkg::SRC_IMMEDIATE;
    c.trig_count   = 13'h1;
    c.timer_cycles = TIMER_DEFAULT;
    c.out_enable   = 1'b0;
    c.in_line      = `IN_LINE_DEF;
    c.out_line     = `OUT_LINE_DEF;
    return c;
  endfunction

  // Maps a line number 1..6 to a one-hot mask
  function automatic logic [LINES-1:0] line_mask(input logic [2:0] line);
    logic [LINES-1:0] m;
    m = '0;
    for (int i = 0; i < LINES; i++) begin
      if (line == 3'(i + 1)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // A count of at least one; zero is treated as one
  function automatic logic [12:0] at_least_one(input logic [12:0] v);
    return (v == 13'h0) ? 13'h1 : v;
  endfunction

  function automatic logic cfg_valid(input trig_seq_pkg::cfg_t c);
    logic [25:0] prod;
    logic        counts_ok;
    logic        lines_ok;
    logic        times_ok;
    prod      = c.trig_count * (c.sweep_enable ? at_least_one(c.sweep_points) : 13'h1);
    counts_ok = (c.trig_count != 13'h0) && (c.trig_count <= 13'(`COUNT_MAX)) &&
                (prod <= 26'(`COUNT_MAX));
    lines_ok  = (c.in_line >= 3'h1) && (c.in_line <= 3'h6) &&
                (c.out_line >= 3'h1) && (c.out_line <= 3'h6);
    // Only upper bounds are checked; short settings are the caller's concern
    times_ok  = (c.delay_cycles <= 25'(`DELAY_MAX_CYC)) &&
                (c.width_cycles <= 18'(`WIDTH_MAX_CYC));
    return counts_ok && lines_ok && times_ok;
  endfunction

  // Power-up state: idle, with the factory configuration
  localparam trig_seq_pkg::cfg_t CFG_RESET = default_cfg('0);
  localparam seq_t SEQ_RESET = '{state: trig_seq_pkg::ST_IDLE, cfg: CFG_RESET, idle: 1'b1,
                                 default: '0};

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_link
      edge_sync u_link (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_in   (i_link_in[g]),
        .o_rise (link_rise[g]),
        .o_fall (link_fall[g])
      );
    end
  endgenerate

  edge_sync u_sot (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_in   (i_start_of_test_input),
    .o_rise (sot_rise),
    .o_fall (sot_fall)
  );

  interval_timer u_timer (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_clear    (timer_clear),
    .i_consume  (timer_consume),
    .i_interval (r.cfg.timer_cycles),
    .o_ready    (timer_ready)
  );

  // Event detector; a low pulse is taken on its falling edge
  always_comb begin
    case (r.cfg.source)
      trig_seq_pkg::SRC_IMMEDIATE: detect = 1'b1;
      trig_seq_pkg::SRC_BUS:       detect = i_cmd.bus_trigger;
      trig_seq_pkg::SRC_TIMER:     detect = timer_ready;
      trig_seq_pkg::SRC_KEY:       detect = i_cmd.key_press & ~i_cmd.remote;
      trig_seq_pkg::SRC_LINK:      detect = |(link_fall & line_mask(r.cfg.in_line));
      trig_seq_pkg::SRC_FALL:      detect = sot_fall;
      trig_seq_pkg::SRC_RISE:      detect = sot_rise;
      trig_seq_pkg::SRC_EITHER:    detect = sot_rise | sot_fall;
      default:                     detect = 1'b0;
    endcase
  end

  assign timer_clear   = (r.state == trig_seq_pkg::ST_IDLE);
  assign timer_consume = (r.state == trig_seq_pkg::ST_WAIT) && detect &&
                         (r.cfg.source == trig_seq_pkg::SRC_TIMER);

  always_comb begin
    logic [24:0] delay_eff;
    logic        layer_done;
    logic        abort_now;
    delay_eff  = '0;
    layer_done = 1'b0;
    abort_now  = i_cmd.abort | i_cmd.front_halt;
    next_r          = r;
    next_r.pulse    = 1'b0;
    next_r.sample   = 1'b0;
    next_r.reading  = 1'b0;
    next_r.filtered = 1'b0;
    next_r.rejected = 1'b0;

    // Configuration writes are taken only while idle; otherwise they are flagged deferred and dropped. Default restore acts in any state
    if (i_cmd.default_restore) begin
      next_r.cfg = default_cfg(r.cfg);
    end else if (i_cfg_write && r.state == trig_seq_pkg::ST_IDLE) begin
      if (cfg_valid(i_cfg)) begin
        next_r.cfg = i_cfg;
      end else begin
        next_r.rejected = 1'b1;
      end
    end
    next_r.deferred = i_cfg_write && (r.state != trig_seq_pkg::ST_IDLE);

    if (i_rearm_set) begin
      next_r.auto_rearm = 1'b1;
    end
    if (i_pulse_mode || i_front_sweep_start) begin
      next_r.auto_rearm = 1'b0;
    end

    case (r.state)
      trig_seq_pkg::ST_IDLE: begin
        if (i_cmd.initiate || i_cmd.front_resume) begin
          next_r.state     = trig_seq_pkg::ST_WAIT;
          next_r.trig_cnt  = 13'h0;
          next_r.point_cnt = 13'h0;
          next_r.filt_cnt  = 8'h0;
        end
      end
      trig_seq_pkg::ST_WAIT: begin
        if (detect) begin
          next_r.state     = trig_seq_pkg::ST_DELAY;
          next_r.phase_cnt = '0;
        end
      end
      trig_seq_pkg::ST_DELAY: begin
        // The delay stretches to the duty-cycle minimum when that is longer
        delay_eff = (r.cfg.delay_cycles > r.cfg.duty_min_cycles) ?
                    r.cfg.delay_cycles : r.cfg.duty_min_cycles;
        if (r.phase_cnt + 25'h1 >= delay_eff) begin
          // Pulse and first sample start together, so the pulse stands its full width
          next_r.state      = trig_seq_pkg::ST_PULSE;
          next_r.phase_cnt  = '0;
          next_r.pulse      = 1'b1;
          next_r.sample     = 1'b1;
          next_r.sample_div = '0;
        end else begin
          next_r.phase_cnt = r.phase_cnt + 25'h1;
        end
      end
      trig_seq_pkg::ST_PULSE: begin
        if (r.phase_cnt + 25'h1 >= 25'(r.cfg.width_cycles)) begin
          next_r.state   = trig_seq_pkg::ST_NEXT;
          next_r.reading = 1'b1;
        end else begin
          next_r.phase_cnt = r.phase_cnt + 25'h1;
          next_r.pulse     = 1'b1;
          if (r.sample_div == 2'(`SAMPLE_DIV - 1)) begin
            next_r.sample     = 1'b1;
            next_r.sample_div = '0;
          end else begin
            next_r.sample_div = r.sample_div + 2'h1;
          end
        end
      end
      trig_seq_pkg::ST_NEXT: begin
        next_r.phase_cnt = '0;
        next_r.state     = trig_seq_pkg::ST_DELAY;
        if (r.cfg.filter_enable && r.filt_cnt + 8'h1 < r.cfg.filter_count) begin
          next_r.filt_cnt = r.filt_cnt + 8'h1;
        end else begin
          next_r.filt_cnt = 8'h0;
          next_r.filtered = 1'b1;
          if (r.cfg.sweep_enable &&
              r.point_cnt + 13'h1 < at_least_one(r.cfg.sweep_points)) begin
            next_r.point_cnt = r.point_cnt + 13'h1;
          end else begin
            next_r.point_cnt = 13'h0;
            next_r.trig_cnt  = r.trig_cnt + 13'h1;
            if (r.trig_cnt + 13'h1 < at_least_one(r.cfg.trig_count)) begin
              next_r.state = trig_seq_pkg::ST_WAIT;
            end else begin
              layer_done   = 1'b1;
              next_r.state = trig_seq_pkg::ST_EXIT;
            end
          end
        end
      end
      trig_seq_pkg::ST_EXIT: begin
        // Auto-rearm loops back; otherwise one initiate gives one cycle
        next_r.state = r.auto_rearm ? trig_seq_pkg::ST_WAIT : trig_seq_pkg::ST_IDLE;
        next_r.trig_cnt = 13'h0;
      end
      default: begin
        next_r.state = trig_seq_pkg::ST_IDLE;
      end
    endcase

    if (abort_now && r.state != trig_seq_pkg::ST_IDLE) begin
      // An abort also drops a reading still in flight
      next_r.state    = trig_seq_pkg::ST_IDLE;
      next_r.pulse    = 1'b0;
      next_r.sample   = 1'b0;
      next_r.reading  = 1'b0;
      next_r.filtered = 1'b0;
      layer_done      = 1'b0;
    end

    // Output trigger pulse on the chosen link line, low-true open drain
    if (layer_done && r.cfg.out_enable) begin
      next_r.out_cnt = 4'(OUT_PULSE);
    end else if (r.out_cnt != 4'h0) begin
      next_r.out_cnt = r.out_cnt - 4'h1;
    end
    next_r.link_oe  = (next_r.out_cnt != 4'h0) ? line_mask(r.cfg.out_line) : '0;
    next_r.link_out = '0;
    next_r.out_evt  = (next_r.out_cnt != 4'h0);
    next_r.idle     = (next_r.state == trig_seq_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= SEQ_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign o_idle                    = r.idle;
  assign o_pulse                   = r.pulse;
  assign o_sample                  = r.sample;
  assign o_reading                 = r.reading;
  assign o_filtered_reading        = r.filtered;
  assign o_sweep_point             = r.point_cnt;
  assign o_cmd_deferred            = r.deferred;
  assign o_auto_rearm              = r.auto_rearm;
  assign o_layer_exit_output_event = r.out_evt;
  assign o_link_out                = r.link_out;
  assign o_link_oe                 = r.link_oe;
  assign o_cfg_rejected            = r.rejected;
  assign o_source                  = r.cfg.source;
endmodule

// ==== trigger_layer_sequencer_monitor.sv ====
// Assertion checker on the trigger layer sequencer ports
module trigger_layer_sequencer_monitor #(
  parameter int LINES     = 6,
  parameter int OUT_PULSE = 4
) (
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_cfg_write,
  input wire trig_seq_pkg::cmd_t i_cmd,
  input wire logic               i_pulse_mode,
  input wire logic               i_front_sweep_start,
  input wire logic               o_idle,
  input wire logic               o_pulse,
  input wire logic               o_sample,
  input wire logic               o_reading,
  input wire logic               o_cmd_deferred,
  input wire logic               o_auto_rearm,
  input wire logic               o_layer_exit_output_event,
  input wire logic [LINES-1:0]   o_link_out,
  input wire logic [LINES-1:0]   o_link_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_idle_stays: assert property (o_idle && !i_cmd.initiate && !i_cmd.front_resume |=> o_idle)
    else $error("idle left without initiate");
  a_init_leaves: assert property (o_idle && i_cmd.initiate |=> !o_idle)
    else $error("initiate ignored in idle");
  a_idle_quiet: assert property (o_idle |-> !o_pulse && !o_reading && !o_sample)
    else $error("activity while idle");
  a_abort_idles: assert property (!o_idle && i_cmd.abort |-> ##[1:2] o_idle)
    else $error("abort did not idle");
  a_cfg_deferred: assert property (i_cfg_write && !o_idle |=> o_cmd_deferred)
    else $error("config write in layer not deferred");
  a_reading_after: assert property ($fell(o_pulse) && !o_idle |-> ##[0:1] o_reading)
    else $error("no reading after pulse");
  a_sample_gap: assert property (o_sample |=> (!o_sample || $rose(o_pulse)) [*3])
    else $error("sample rate too high");
  a_sample_inside: assert property (o_sample |-> o_pulse)
    else $error("sample outside pulse");
  a_trig_width: assert property ($rose(o_layer_exit_output_event)
    |-> o_layer_exit_output_event [*4] ##1 !o_layer_exit_output_event)
    else $error("output trigger width wrong");
  a_one_line: assert property ($onehot0(o_link_oe) && (|o_link_oe == o_layer_exit_output_event)
    && o_link_out == '0)
    else $error("output trigger line wrong");
  a_rearm_off: assert property (i_pulse_mode || i_front_sweep_start |=> !o_auto_rearm)
    else $error("auto rearm not cleared");
  c_exit: cover property ($rose(o_layer_exit_output_event));
  c_abort: cover property (!o_idle && i_cmd.abort);
  c_defer: cover property (o_cmd_deferred);
endmodule

bind trigger_layer_sequencer trigger_layer_sequencer_monitor #(
  .LINES(LINES), .OUT_PULSE(OUT_PULSE)) i_trigger_layer_sequencer_monitor (
  .i_clk, .i_rst, .i_cfg_write, .i_cmd, .i_pulse_mode, .i_front_sweep_start, .o_idle,
  .o_pulse, .o_sample, .o_reading, .o_cmd_deferred, .o_auto_rearm,
  .o_layer_exit_output_event, .o_link_out, .o_link_oe);

// ==== trigger_layer_sequencer_test.sv ====
// Self-checking bench for the trigger layer sequencer
module trigger_layer_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] INIT = 8'h80, ABT = 8'h40, BUSTRG = 8'h20, DEFR = 8'h10;
  localparam logic [7:0] HALT = 8'h08, RESUME = 8'h04, KEY = 8'h02;
  logic               i_clk = 1'b0;
  logic               i_rst = 1'b1;
  trig_seq_pkg::cfg_t cfg = '0;
  trig_seq_pkg::cmd_t cmd = '0;
  trig_seq_pkg::cfg_t c;
  trig_seq_pkg::src_t s;
  logic               wr = 1'b0, pmode = 1'b0, fsweep = 1'b0, rearm = 1'b0;
  logic [5:0]         link, oe, oe_seen;
  logic               start_of_test_input, idle, rd, frd, arm, evt, rej, pul;
  logic [2:0]         src;
  logic [12:0]        pt, max_pt;
  logic               evt_q = 1'b0;
  int                 err_count = 0, check_count = 0, n_rd, n_frd, n_evt, n_rej, cyc = 0, i;
  int                 n_pul, n_busy;
  always #12.5 i_clk = ~i_clk;
  trig_partner i_trig_partner (.i_clk(i_clk), .i_oe(oe), .o_link(link), .o_sot(start_of_test_input));
  trigger_layer_sequencer #(.TIMER_DEFAULT(32'h00000032)) i_trigger_layer_sequencer (
    .i_clk(i_clk), .i_rst(i_rst), .i_cfg(cfg), .i_cfg_write(wr), .i_cmd(cmd),
    .i_pulse_mode(pmode), .i_front_sweep_start(fsweep), .i_rearm_set(rearm),
    .i_link_in(link), .i_start_of_test_input(start_of_test_input), .o_idle(idle), .o_pulse(pul),
    .o_sample(), .o_reading(rd), .o_filtered_reading(frd), .o_sweep_point(pt),
    .o_cmd_deferred(), .o_auto_rearm(arm), .o_layer_exit_output_event(evt),
    .o_link_out(), .o_link_oe(oe), .o_cfg_rejected(rej), .o_source(src));
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    evt_q <= evt;
    if (rd === 1'b1) n_rd <= n_rd + 1;
    if (frd === 1'b1) n_frd <= n_frd + 1;
    if (rej === 1'b1) n_rej <= n_rej + 1;
    if (pul === 1'b1) n_pul <= n_pul + 1;
    if (idle === 1'b0) n_busy <= n_busy + 1;
    if (pt > max_pt) max_pt <= pt;
    if (evt === 1'b1 && evt_q !== 1'b1) n_evt <= n_evt + 1;
    if (evt === 1'b1) oe_seen <= oe;
    // Generous ceiling: the whole sequence needs well under two thousand cycles
    if (cyc == 50000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmd1(input logic [7:0] m);
    @(negedge i_clk) cmd = m | {7'h00, cmd.remote};
    @(negedge i_clk) cmd = {7'h00, cmd.remote};
  endtask
  task automatic cfgw(input trig_seq_pkg::cfg_t v);
    @(negedge i_clk) cfg = v;
    wr = 1'b1;
    @(negedge i_clk) wr = 1'b0;
  endtask
  task automatic clr();
    @(negedge i_clk) n_rd = 0;
    n_frd = 0;
    n_evt = 0;
    n_rej = 0;
    n_pul = 0;
    n_busy = 0;
    max_pt = '0;
  endtask
  task automatic waitidle();
    int k;
    for (k = 0; k < 4000 && idle !== 1'b1; k++) @(negedge i_clk);
    chk(idle, 1'b1);
    repeat (2) @(negedge i_clk);
  endtask
  function automatic trig_seq_pkg::cfg_t mk(input trig_seq_pkg::src_t sv);
    trig_seq_pkg::cfg_t v;
    v = '0;
    v.source = sv;
    v.in_line = 3'h4;
    v.out_line = 3'h3;
    v.trig_count = 13'h0001;
    v.sweep_points = 13'h0001;
    v.filter_count = 8'h01;
    v.timer_cycles = 32'h000000C8;
    v.delay_cycles = 25'h0000002;
    v.width_cycles = 18'h00008;
    return v;
  endfunction
  task automatic fire(input trig_seq_pkg::src_t sv);
    case (sv)
      trig_seq_pkg::SRC_BUS: cmd1(BUSTRG);
      trig_seq_pkg::SRC_KEY: begin
        cmd.remote = 1'b1;
        cmd1(KEY);
        repeat (10) @(negedge i_clk);
        chk(n_rd, 0);
        cmd.remote = 1'b0;
        cmd1(KEY);
      end
      trig_seq_pkg::SRC_LINK: begin
        i_trig_partner.link_pulse(1);
        repeat (10) @(negedge i_clk);
        chk(n_rd, 0);
        i_trig_partner.link_pulse(4);
      end
      trig_seq_pkg::SRC_FALL: i_trig_partner.sot_pulse(1'b0);
      default: i_trig_partner.sot_pulse(1'b1);
    endcase
  endtask
  initial begin
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    chk(src, trig_seq_pkg::SRC_IMMEDIATE);
    clr();
    cmd1(INIT);
    waitidle();
    chk(n_rd, 1);
    chk(n_evt, 0);
    chk(n_pul, 32'h1);
    chk(n_busy, 32'h5);
    $display("test 1 done");
    c = mk(trig_seq_pkg::SRC_IMMEDIATE);
    c.trig_count = 13'h0003;
    c.sweep_points = 13'h0002;
    c.sweep_enable = 1'b1;
    c.filter_count = 8'h02;
    c.filter_enable = 1'b1;
    c.out_enable = 1'b1;
    cfgw(c);
    clr();
    cmd1(INIT);
    waitidle();
    chk(n_rd, 12);
    chk(n_frd, 6);
    chk(n_evt, 1);
    chk(oe_seen, 6'h04);
    chk(n_pul, 32'h60);
    chk(max_pt, 32'h1);
    c.trig_count = 13'h1388;
    cfgw(c);
    repeat (3) @(negedge i_clk);
    chk(n_rej, 1);
    c = mk(trig_seq_pkg::SRC_IMMEDIATE);
    c.duty_min_cycles = 25'h000003C;
    cfgw(c);
    clr();
    cmd1(INIT);
    waitidle();
    chk(n_busy, 32'h47);
    $display("test 2 done");
    for (i = 0; i < 6; i++) begin
      s = trig_seq_pkg::src_t'(i + 1);
      if (s == trig_seq_pkg::SRC_TIMER) s = trig_seq_pkg::SRC_EITHER;
      cfgw(mk(s));
      clr();
      cmd1(INIT);
      repeat (20) @(negedge i_clk);
      chk(n_rd, 0);
      fire(s);
      waitidle();
      chk(n_rd, 1);
    end
    $display("test 3 done");
    c = mk(trig_seq_pkg::SRC_TIMER);
    c.trig_count = 13'h0002;
    cfgw(c);
    clr();
    cmd1(INIT);
    repeat (40) @(negedge i_clk);
    chk(n_rd, 1);
    waitidle();
    chk(n_rd, 2);
    cmd1(INIT);
    repeat (40) @(negedge i_clk);
    chk(n_rd, 3);
    waitidle();
    $display("test 4 done");
    cfgw(mk(trig_seq_pkg::SRC_BUS));
    cmd1(INIT);
    cfgw(mk(trig_seq_pkg::SRC_KEY));
    chk(src, trig_seq_pkg::SRC_BUS);
    cmd1(ABT);
    repeat (2) @(negedge i_clk);
    chk(idle, 1'b1);
    cmd1(INIT);
    cmd1(HALT);
    repeat (2) @(negedge i_clk);
    chk(idle, 1'b1);
    cmd1(RESUME);
    chk(idle, 1'b0);
    cmd1(ABT);
    cmd1(DEFR);
    repeat (2) @(negedge i_clk);
    chk(src, trig_seq_pkg::SRC_IMMEDIATE);
    @(negedge i_clk) rearm = 1'b1;
    @(negedge i_clk) rearm = 1'b0;
    chk(arm, 1'b1);
    @(negedge i_clk) pmode = 1'b1;
    @(negedge i_clk) pmode = 1'b0;
    chk(arm, 1'b0);
    @(negedge i_clk) rearm = 1'b1;
    @(negedge i_clk) rearm = 1'b0;
    @(negedge i_clk) fsweep = 1'b1;
    @(negedge i_clk) fsweep = 1'b0;
    chk(arm, 1'b0);
    cfgw(mk(trig_seq_pkg::SRC_BUS));
    clr();
    @(negedge i_clk) rearm = 1'b1;
    @(negedge i_clk) rearm = 1'b0;
    cmd1(INIT);
    cmd1(BUSTRG);
    repeat (30) @(negedge i_clk);
    chk(idle, 1'b0);
    cmd1(BUSTRG);
    repeat (30) @(negedge i_clk);
    chk(n_rd, 2);
    cmd1(ABT);
    repeat (2) @(negedge i_clk);
    chk(idle, 1'b1);
    $display("test 5 done");
    test_done();
  end
endmodule
